/* File: hw/uwbg_defs.vh */
// uwbg_defs.vh: register offsets, field positions, reset values and timing for the uart block
// assumes: included by the design file, the checker and the bench, by bare name
`ifndef UWBG_DEFS_VH
`define UWBG_DEFS_VH

// ----------------------------------------------------------------------------
// register offsets (3-bit index)
// ----------------------------------------------------------------------------
`define UWBG_A_BDH      3'h0
`define UWBG_A_BDL      3'h1
`define UWBG_A_CTRL1    3'h2
`define UWBG_A_CTRL2    3'h3
`define UWBG_A_STAT     3'h4
`define UWBG_A_CTRL3    3'h5
`define UWBG_A_DATA     3'h6
`define UWBG_A_INTEN    3'h7

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define UWBG_BDH_RST    5'h00
`define UWBG_BDL_RST    8'h04
`define UWBG_ZERO13     13'h0000
`define UWBG_STAT_RST   8'hC0

// ----------------------------------------------------------------------------
// control register 1 fields
// ----------------------------------------------------------------------------
`define UWBG_C1_LOOP    7
`define UWBG_C1_M       4
`define UWBG_C1_WAKE    3
`define UWBG_C1_ILT     2
`define UWBG_C1_PE      1
`define UWBG_C1_PT      0

// ----------------------------------------------------------------------------
// control register 2 fields
// ----------------------------------------------------------------------------
`define UWBG_C2_TE      3
`define UWBG_C2_RE      2
`define UWBG_C2_RWU     1

// ----------------------------------------------------------------------------
// status bits (status, clear and enable share this layout)
// ----------------------------------------------------------------------------
`define UWBG_S_TDRE     7
`define UWBG_S_TC       6
`define UWBG_S_RDRF     5
`define UWBG_S_IDLE     4
`define UWBG_S_OR       3
`define UWBG_S_NF       2
`define UWBG_S_FE       1
`define UWBG_S_PF       0

// ----------------------------------------------------------------------------
// bit timing in oversampling ticks
// ----------------------------------------------------------------------------
`define UWBG_TICK_LAST  4'hF
`define UWBG_SMP_A      4'h7
`define UWBG_SMP_B      4'h8
`define UWBG_SMP_C      4'h9
`define UWBG_HALF       4'h7

`endif

/* File: hw/uwbg_uart.v */
// uwbg_uart.v: uart with 13-bit modulo baud generator, 8-bit register port
// assumes: one 40 MHz clock, pins asynchronous, stop request from the system
//
// Operation
// - baud = clock / (16 x divisor) for divisor 1..8191
// - divisor zero stops the baud generator completely
// - upper divisor write is buffered until lower divisor is written
// - generator idle after reset until receiver or transmitter enable written 1
// - transmitter and receiver share one generator per instance
// - all serial activity halts in stop mode
// - eight or nine data bits in both directions
// - nrz framing, full duplex on separate lines
// - double buffered transmit and receive, separate enables
// - parity generated on transmit, checked on receive when enabled
// - receiver wakes on idle line or address mark
// - reports tdre, tc, rdrf, overrun, parity, framing, noise, idle
// - three-sample majority recovers data and flags noise
// - eight registers, eight bits each
// - loop mode feeds transmitter output to the receiver
// - nine-bit frame: start, eight lsb-first bits, ninth bit, stop
// - parity makes ones count even or odd per parity type
`include "uwbg_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module uwbg_uart (
    input  wire       clk,
    input  wire       nrst,
    input  wire [2:0] addr,
    input  wire [7:0] wdata,
    input  wire       wr,
    input  wire       rd,
    output reg  [7:0] rdata,
    input  wire       stop_mode,
    input  wire       rxd_pin,
    output reg        txd_pin,
    output reg        irq
);

    function [1:0] maj3;
        input a;
        input b;
        input c;
        begin
            maj3[0] = (a & b) | (a & c) | (b & c);
            maj3[1] = ~((a == b) & (b == c));
        end
    endfunction

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    reg  [4:0]  bdh_buf_r;
    reg  [12:0] baud_modulo_value_r;
    reg  [7:0]  ctrl1_r;
    reg  [7:0]  ctrl2_r;
    reg  [7:0]  stat_r;
    reg  [7:0]  inten_r;
    reg         gen_armed_r;
    reg         ninth_tx_r;
    reg  [7:0]  txbuf_r;
    reg         txbuf_ninth_r;
    reg  [8:0]  rxbuf_r;

    wire sel_wr_bdh = wr & (addr == `UWBG_A_BDH);
    wire sel_wr_bdl = wr & (addr == `UWBG_A_BDL);
    wire sel_wr_c1  = wr & (addr == `UWBG_A_CTRL1);
    wire sel_wr_c2  = wr & (addr == `UWBG_A_CTRL2);
    wire sel_wr_clr = wr & (addr == `UWBG_A_STAT);
    wire sel_wr_c3  = wr & (addr == `UWBG_A_CTRL3);
    wire sel_wr_dat = wr & (addr == `UWBG_A_DATA);
    wire sel_wr_ien = wr & (addr == `UWBG_A_INTEN);
    wire sel_rd_dat = rd & (addr == `UWBG_A_DATA);

    wire te      = ctrl2_r[`UWBG_C2_TE];
    wire re      = ctrl2_r[`UWBG_C2_RE];
    wire nine    = ctrl1_r[`UWBG_C1_M];
    wire par_en  = ctrl1_r[`UWBG_C1_PE];
    wire par_odd = ctrl1_r[`UWBG_C1_PT];

    // ------------------------------------------------------------------------
    // baud generator
    // ------------------------------------------------------------------------
    reg  [12:0] bcnt_r;
    reg         tick_r;
    wire        gen_run = gen_armed_r & (baud_modulo_value_r != `UWBG_ZERO13) & ~stop_mode;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bcnt_r <= 13'h0000;
            tick_r <= 1'b0;
        end else if (!gen_run) begin
            bcnt_r <= 13'h0000;
            tick_r <= 1'b0;
        end else if (bcnt_r >= baud_modulo_value_r - 13'h0001) begin
            bcnt_r <= 13'h0000;
            tick_r <= 1'b1;
        end else begin
            bcnt_r <= bcnt_r + 13'h0001;
            tick_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // receive pin synchroniser and loop select
    // ------------------------------------------------------------------------
    reg  rx_s1_r;
    reg  rx_s2_r;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
        end else begin
            rx_s1_r <= rxd_pin;
            rx_s2_r <= rx_s1_r;
        end
    end
    wire rx_in = ctrl1_r[`UWBG_C1_LOOP] ? txd_pin : rx_s2_r;

    // ------------------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------------------
    reg  [3:0]  ttick_r;
    reg  [3:0]  tbit_r;
    reg         tbusy_r;
    reg  [10:0] tsh_r;
    wire [3:0]  tlast = nine ? 4'hA : 4'h9;
    wire        tx_par = ^{txbuf_r, txbuf_ninth_r & nine} ^ par_odd;
    wire [8:0]  tx_word;
    assign tx_word[7:0] = (par_en & ~nine) ? {tx_par ^ txbuf_r[7], txbuf_r[6:0]} : txbuf_r;
    assign tx_word[8]   = (par_en & nine) ? (^txbuf_r ^ par_odd) : txbuf_ninth_r;
    wire        tx_load = tick_r & te & ~tbusy_r & ~stat_r[`UWBG_S_TDRE];
    wire        tx_done = tick_r & tbusy_r & (ttick_r == `UWBG_TICK_LAST) & (tbit_r == tlast);

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ttick_r <= 4'h0;
            tbit_r  <= 4'h0;
            tbusy_r <= 1'b0;
            tsh_r   <= 11'h7FF;
            txd_pin <= 1'b1;
        end else if (tx_load) begin
            tbusy_r <= 1'b1;
            ttick_r <= 4'h0;
            tbit_r  <= 4'h0;
            tsh_r   <= nine ? {1'b1, tx_word, 1'b0} : {2'b11, tx_word[7:0], 1'b0};
            txd_pin <= 1'b0;
        end else if (tick_r & tbusy_r) begin
            ttick_r <= ttick_r + 4'h1;
            if (ttick_r == `UWBG_TICK_LAST) begin
                tbit_r  <= tbit_r + 4'h1;
                tsh_r   <= {1'b1, tsh_r[10:1]};
                txd_pin <= tsh_r[1];
                if (tbit_r == tlast) begin
                    tbusy_r <= 1'b0;
                    txd_pin <= 1'b1;
                end
            end
        end else if (!te) begin
            txd_pin <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // receiver: start hunt, 3-sample majority, wakeup
    // ------------------------------------------------------------------------
    reg  [3:0]  rtick_r;
    reg  [3:0]  rbit_r;
    reg         rbusy_r;
    reg  [8:0]  rsh_r;
    reg         s_a_r;
    reg         s_b_r;
    reg         noise_r;
    reg  [4:0]  idle_cnt_r;
    reg         idle_armed_r;
    wire [3:0]  rlast = nine ? 4'hA : 4'h9;
    wire [1:0]  mv    = maj3(s_a_r, s_b_r, rx_in);
    wire        r_smp = tick_r & rbusy_r & (rtick_r == `UWBG_SMP_C);
    wire        r_stop = r_smp & (rbit_r == rlast);
    wire [8:0]  rword = nine ? rsh_r : {1'b0, rsh_r[8:1]};
    wire        r_par_bad = par_en & ((nine ? ^rword : ^rword[7:0]) ^ par_odd);
    wire        rwu   = ctrl2_r[`UWBG_C2_RWU];
    wire        addr_mark = nine ? rword[8] : rword[7];
    wire        r_keep = ~rwu | (ctrl1_r[`UWBG_C1_WAKE] & addr_mark);
    wire [4:0]  idle_len = nine ? 5'h0B : 5'h0A;
    wire        idle_hit = tick_r & re & ~rbusy_r & idle_armed_r & rx_in & (rtick_r == `UWBG_TICK_LAST)
                           & (idle_cnt_r == idle_len - 5'h01);
    wire        rx_good = r_stop & mv[0] & r_keep;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rtick_r      <= 4'h0;
            rbit_r       <= 4'h0;
            rbusy_r      <= 1'b0;
            rsh_r        <= 9'h000;
            s_a_r        <= 1'b1;
            s_b_r        <= 1'b1;
            noise_r      <= 1'b0;
            idle_cnt_r   <= 5'h00;
            idle_armed_r <= 1'b0;
        end else if (!re) begin
            rbusy_r    <= 1'b0;
            rtick_r    <= 4'h0;
            idle_cnt_r <= 5'h00;
        end else if (tick_r) begin
            if (rtick_r == `UWBG_SMP_A) s_a_r <= rx_in;
            if (rtick_r == `UWBG_SMP_B) s_b_r <= rx_in;
            if (!rbusy_r) begin
                if (!rx_in) begin
                    rbusy_r      <= 1'b1;
                    rtick_r      <= 4'h1;
                    rbit_r       <= 4'h0;
                    noise_r      <= 1'b0;
                    idle_armed_r <= 1'b1;
                    idle_cnt_r   <= 5'h00;
                end else begin
                    rtick_r <= rtick_r + 4'h1;
                    if (rtick_r == `UWBG_TICK_LAST)
                        idle_cnt_r <= (idle_cnt_r == idle_len) ? idle_cnt_r : idle_cnt_r + 5'h01;
                end
            end else begin
                rtick_r <= rtick_r + 4'h1;
                if (rtick_r == `UWBG_SMP_C) begin
                    noise_r <= noise_r | mv[1];
                    if (rbit_r == 4'h0 && mv[0]) begin
                        rbusy_r <= 1'b0;
                    end else if (rbit_r == rlast) begin
                        rbusy_r    <= 1'b0;
                        rtick_r    <= `UWBG_HALF;
                        idle_cnt_r <= ctrl1_r[`UWBG_C1_ILT] ? 5'h00 : rlast + 5'h00;
                    end else begin
                        rsh_r <= {mv[0], rsh_r[8:1]};
                    end
                    rbit_r <= rbit_r + 4'h1;
                end
            end
            if (idle_hit) idle_armed_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // register writes, status flags (set wins over clear), interrupt
    // ------------------------------------------------------------------------
    reg  [7:0] stat_nxt;
    always @* begin
        stat_nxt = stat_r;
        if (sel_wr_clr) stat_nxt = stat_nxt & ~(wdata & 8'h1F);
        if (sel_wr_dat) begin
            stat_nxt[`UWBG_S_TDRE] = 1'b0;
            stat_nxt[`UWBG_S_TC]   = 1'b0;
        end
        if (sel_rd_dat) stat_nxt[`UWBG_S_RDRF] = 1'b0;
        if (tx_load) stat_nxt[`UWBG_S_TDRE] = 1'b1;
        if (tx_done & stat_r[`UWBG_S_TDRE]) stat_nxt[`UWBG_S_TC] = 1'b1;
        if (idle_hit & ~rwu) stat_nxt[`UWBG_S_IDLE] = 1'b1;
        if (rx_good) begin
            if (stat_r[`UWBG_S_RDRF]) stat_nxt[`UWBG_S_OR] = 1'b1;
            else begin
                stat_nxt[`UWBG_S_RDRF] = 1'b1;
                stat_nxt[`UWBG_S_NF]   = noise_r | mv[1];
                stat_nxt[`UWBG_S_PF]   = r_par_bad;
            end
        end
        if (r_stop & ~mv[0] & r_keep) stat_nxt[`UWBG_S_FE] = 1'b1;
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bdh_buf_r           <= `UWBG_BDH_RST;
            baud_modulo_value_r <= {`UWBG_BDH_RST, `UWBG_BDL_RST};
            ctrl1_r             <= 8'h00;
            ctrl2_r             <= 8'h00;
            stat_r              <= `UWBG_STAT_RST;
            inten_r             <= 8'h00;
            gen_armed_r         <= 1'b0;
            ninth_tx_r          <= 1'b0;
            txbuf_r             <= 8'h00;
            txbuf_ninth_r       <= 1'b0;
            rxbuf_r             <= 9'h000;
            irq                 <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            irq    <= |(stat_r & inten_r);
            if (sel_wr_bdh) bdh_buf_r <= wdata[4:0];
            if (sel_wr_bdl) baud_modulo_value_r <= {bdh_buf_r, wdata};
            if (sel_wr_c1) ctrl1_r <= wdata;
            if (sel_wr_c2) begin
                ctrl2_r <= wdata;
                if (wdata[`UWBG_C2_TE] | wdata[`UWBG_C2_RE]) gen_armed_r <= 1'b1;
            end
            if (sel_wr_c3) ninth_tx_r <= wdata[0];
            if (sel_wr_ien) inten_r <= wdata;
            if (sel_wr_dat) begin
                txbuf_r       <= wdata;
                txbuf_ninth_r <= ninth_tx_r;
            end
            if (rx_good & ~stat_r[`UWBG_S_RDRF]) rxbuf_r <= rword;
            if (idle_hit & rwu & ~ctrl1_r[`UWBG_C1_WAKE]) ctrl2_r[`UWBG_C2_RWU] <= 1'b0;
            if (r_stop & rwu & r_keep) ctrl2_r[`UWBG_C2_RWU] <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // read data, one cycle after the strobe
    // ------------------------------------------------------------------------
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= 8'h00;
        end else if (rd) begin
            case (addr)
                `UWBG_A_BDH:   rdata <= {3'h0, bdh_buf_r};
                `UWBG_A_BDL:   rdata <= baud_modulo_value_r[7:0];
                `UWBG_A_CTRL1: rdata <= ctrl1_r;
                `UWBG_A_CTRL2: rdata <= ctrl2_r;
                `UWBG_A_STAT:  rdata <= stat_r;
                `UWBG_A_CTRL3: rdata <= {rxbuf_r[8], 6'h00, ninth_tx_r};
                `UWBG_A_DATA:  rdata <= rxbuf_r[7:0];
                default:       rdata <= inten_r;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

endmodule // uwbg_uart
`default_nettype wire

/* File: tb/uwbg_chk.sv */
// uwbg_chk.sv: port assertions for the uart block, bound to uwbg_uart
// assumes: divisor and enables are shadowed from the register port
`timescale 1ns/100ps
`default_nettype none
`include "uwbg_defs.vh"
module uwbg_chk (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       stop_mode,
    input wire logic       txd_pin,
    input wire logic       irq
);
    logic [4:0]  bdh_buf_r;
    logic [4:0]  div_hi_r;
    logic [7:0]  div_lo_r;
    logic [7:0]  int_en_r;
    logic        en_seen_r;
    logic [31:0] low_run_r;
    wire  [12:0] div = {div_hi_r, div_lo_r};
    // ----------------
    // register shadows
    // ----------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bdh_buf_r <= `UWBG_BDH_RST;
            div_hi_r  <= `UWBG_BDH_RST;
            div_lo_r  <= `UWBG_BDL_RST;
            int_en_r  <= 8'h00;
            en_seen_r <= 1'b0;
        end else if (wr) begin
            if (addr == `UWBG_A_BDH)
                bdh_buf_r <= wdata[4:0];
            if (addr == `UWBG_A_BDL) begin
                div_hi_r <= bdh_buf_r;
                div_lo_r <= wdata;
            end
            if (addr == `UWBG_A_INTEN)
                int_en_r <= wdata;
            if (addr == `UWBG_A_CTRL2 && (wdata[`UWBG_C2_TE] || wdata[`UWBG_C2_RE]))
                en_seen_r <= 1'b1;
        end
    end
    // length of the current low run on the serial output
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            low_run_r <= 32'h0;
        else
            low_run_r <= txd_pin ? 32'h0 : low_run_r + 32'h1;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    sequence s_bdh_read;
        rd && addr == `UWBG_A_BDH;
    endsequence
    sequence s_stop_two;
        stop_mode ##1 stop_mode;
    endsequence
    rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
        else $error("read data not zero outside a read");
    bdh_read_a: assert property (s_bdh_read |=> rdata == {3'h0, $past(bdh_buf_r)})
        else $error("upper divisor read wrong");
    bdl_read_a: assert property (rd && addr == `UWBG_A_BDL |=> rdata == $past(div_lo_r))
        else $error("lower divisor read wrong");
    baud_gate_a: assert property (!en_seen_r |-> txd_pin)
        else $error("serial output active before enable");
    div_zero_a: assert property (div == 13'h0000 && txd_pin |=> txd_pin)
        else $error("serial output moved with divisor zero");
    stop_hold_a: assert property (s_stop_two |=> $stable(txd_pin))
        else $error("serial output moved in stop mode");
    bit_time_a: assert property ($rose(txd_pin) && div != 13'h0000 |-> (low_run_r % {div, 4'h0}) == 32'h0)
        else $error("low run not a whole number of bit times");
    irq_mask_a: assert property (int_en_r == 8'h00 |=> !irq)
        else $error("interrupt high with all enables off");
endmodule // uwbg_chk
bind uwbg_uart uwbg_chk i_chk (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .stop_mode(stop_mode), .txd_pin(txd_pin), .irq(irq));
`default_nettype wire

/* File: tb/uwbg_peer.sv */
// uwbg_peer.sv: remote serial port, frames sent and received by task
// assumes: shares the block clock; bench sets the bit length in clocks
`timescale 1ns/100ps
`default_nettype none
module uwbg_peer (
    input  wire logic clk,
    input  wire logic txd_pin,
    output var  logic rxd_pin
);
    int bit_clks = 32;
    initial rxd_pin = 1'b1;
    // ----------------
    // frame tasks
    // ----------------
    task automatic send(input logic [8:0] val, input int nbits, input logic stop_bit);
        rxd_pin <= 1'b0;
        repeat (bit_clks) @(posedge clk);
        for (int i = 0; i < nbits; i++) begin
            rxd_pin <= val[i];
            repeat (bit_clks) @(posedge clk);
        end
        rxd_pin <= stop_bit;
        repeat (bit_clks) @(posedge clk);
        rxd_pin <= 1'b1;
    endtask
    // returns data bits lsb first with the stop bit above them
    task automatic recv(input int nbits, output logic [9:0] val);
        val = 10'h000;
        @(negedge txd_pin);
        repeat (bit_clks / 2) @(posedge clk);
        for (int i = 0; i <= nbits; i++) begin
            repeat (bit_clks) @(posedge clk);
            val[i] = txd_pin;
        end
    endtask
endmodule // uwbg_peer
`default_nettype wire

/* File: tb/tb.sv */
// tb.sv: register-level tests of the uart block with a remote port model
// assumes: uwbg_defs.vh on the include path, 40 MHz clock
`timescale 1ns/100ps
`default_nettype none
`include "uwbg_defs.vh"
module tb;
    logic            clk = 1'b0;
    logic            nrst = 1'b0;
    logic [2:0]      addr = 3'h0;
    logic [7:0]      wdata = 8'h00;
    logic            wr = 1'b0;
    logic            rd = 1'b0;
    logic            stop_mode = 1'b0;
    wire logic [7:0] rdata;
    wire logic       rxd_pin;
    wire logic       txd_pin;
    wire logic       irq;
    int              errors = 0;
    int              compares = 0;
    logic [7:0]      rv;
    logic [9:0]      fr;
    always #12.5 clk = ~clk;
    uwbg_uart i_dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
                     .stop_mode(stop_mode), .rxd_pin(rxd_pin), .txd_pin(txd_pin), .irq(irq));
    uwbg_peer i_peer (.clk(clk), .txd_pin(txd_pin), .rxd_pin(rxd_pin));
    // ----------------
    // bus and compare tasks
    // ----------------
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
        @(posedge clk);
    endtask
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
        rd_reg(a, rv);
        chk({2'h0, rv & m}, {2'h0, e});
    endtask
    task automatic wait_flag(input int b);
        rv = 8'h00;
        for (int n = 0; n < 3000 && rv[b] !== 1'b1; n++)
            rd_reg(`UWBG_A_STAT, rv);
        chk({9'h0, rv[b]}, 10'h001);
        rv = 8'h00;
    endtask
    task automatic tx_frame(input logic [7:0] d, input int nb, input logic [9:0] e);
        fork
            i_peer.recv(nb, fr);
            wr_reg(`UWBG_A_DATA, d);
        join
        chk(fr, e);
    endtask
    task automatic irq_chk(input logic e);
        repeat (3) @(posedge clk);
        #1 chk({9'h0, irq}, {9'h0, e});
        @(posedge clk);
    endtask
    task automatic held_tx(input logic [7:0] d);
        wr_reg(`UWBG_A_DATA, d);
        repeat (600) @(posedge clk);
        #1 chk({9'h0, txd_pin}, 10'h001);
        @(posedge clk);
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        final_report;
    end
    initial begin
        rv = 8'h00;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd_chk(`UWBG_A_STAT, 8'hFF, 8'hC0);
        rd_chk(`UWBG_A_BDL, 8'hFF, `UWBG_BDL_RST);
        repeat (200) @(posedge clk);
        wr_reg(`UWBG_A_BDH, 8'h01);
        rd_chk(`UWBG_A_BDH, 8'h1F, 8'h01);
        wr_reg(`UWBG_A_CTRL2, 8'h0C);
        i_peer.bit_clks = 64;
        tx_frame(8'hA5, 8, 10'h1A5);
        wr_reg(`UWBG_A_BDH, 8'h00);
        wr_reg(`UWBG_A_BDL, 8'h02);
        i_peer.bit_clks = 32;
        fork
            begin
                tx_frame(8'h5A, 8, 10'h15A);
                i_peer.recv(8, fr);
                chk(fr, 10'h1C3);
            end
            begin
                // let the data write own the bus before polling starts
                repeat (2) @(posedge clk);
                wait_flag(`UWBG_S_TDRE);
                wr_reg(`UWBG_A_DATA, 8'hC3);
            end
            i_peer.send(9'h03C, 8, 1'b1);
        join
        i_peer.send(9'h096, 8, 1'b1);
        rd_chk(`UWBG_A_STAT, 8'h28, 8'h28);
        rd_chk(`UWBG_A_DATA, 8'hFF, 8'h3C);
        wr_reg(`UWBG_A_STAT, 8'h08);
        rd_chk(`UWBG_A_STAT, 8'h08, 8'h00);
        wr_reg(`UWBG_A_INTEN, 8'h20);
        i_peer.send(9'h011, 8, 1'b1);
        irq_chk(1'b1);
        wr_reg(`UWBG_A_INTEN, 8'h00);
        irq_chk(1'b0);
        wr_reg(`UWBG_A_INTEN, 8'h20);
        irq_chk(1'b1);
        rd_chk(`UWBG_A_DATA, 8'hFF, 8'h11);
        irq_chk(1'b0);
        wr_reg(`UWBG_A_CTRL1, 8'h10);
        wr_reg(`UWBG_A_CTRL3, 8'h01);
        tx_frame(8'h5A, 9, 10'h35A);
        i_peer.send(9'h1C3, 9, 1'b1);
        wait_flag(`UWBG_S_RDRF);
        rd_chk(`UWBG_A_CTRL3, 8'h80, 8'h80);
        rd_chk(`UWBG_A_DATA, 8'hFF, 8'hC3);
        for (int p = 0; p < 2; p++) begin
            wr_reg(`UWBG_A_CTRL1, {7'h01, p[0]});
            tx_frame(8'h07, 8, p[0] ? 10'h107 : 10'h187);
        end
        i_peer.send(9'h087, 8, 1'b1);
        wait_flag(`UWBG_S_PF);
        rd_reg(`UWBG_A_DATA, rv);
        wr_reg(`UWBG_A_STAT, 8'h01);
        i_peer.send(9'h007, 8, 1'b0);
        wait_flag(`UWBG_S_FE);
        wr_reg(`UWBG_A_STAT, 8'h02);
        rd_chk(`UWBG_A_STAT, 8'h03, 8'h00);
        rd_reg(`UWBG_A_DATA, rv);
        wr_reg(`UWBG_A_CTRL1, 8'h00);
        wr_reg(`UWBG_A_BDL, 8'h00);
        held_tx(8'h33);
        fork
            i_peer.recv(8, fr);
            wr_reg(`UWBG_A_BDL, 8'h02);
        join
        chk(fr, 10'h133);
        stop_mode <= 1'b1;
        @(posedge clk);
        held_tx(8'h4B);
        fork
            i_peer.recv(8, fr);
            stop_mode <= 1'b0;
        join
        chk(fr, 10'h14B);
        wr_reg(`UWBG_A_CTRL1, 8'h80);
        wr_reg(`UWBG_A_DATA, 8'h69);
        wait_flag(`UWBG_S_RDRF);
        rd_chk(`UWBG_A_DATA, 8'hFF, 8'h69);
        final_report;
    end
endmodule // tb
`default_nettype wire
